/* File: core/vcd_config_space.sv */
// Configuration-space register block of a register-based extended slave.
`include "vcd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module vcd_config_space
   import vcd_pkg::*;
#(
   parameter logic [3:0] REQ_MEM = 4'h9,
   parameter logic [1:0] ADDR_MODE = 2'h0,
   parameter logic [11:0] MAKER_ID = 12'h123,
   parameter logic [11:0] MODEL_CODE = 12'h001
) (
   // Clock and reset.
   input wire logic CLK,
   input wire logic RST_N,
   // Address straps and select line.
   input wire logic [7:0] LA_SWITCH,
   input wire logic MODULE_SELECT_LINE,
   // A16 access, one strobe cycle per transfer.
   input wire logic ACC_STB,
   input wire logic ACC_WR,
   input wire logic ACC_D16,
   input wire logic [15:0] ACC_ADDR,
   input wire logic [15:0] ACC_WDATA,
   output logic ACC_ACK,
   output logic [15:0] ACC_RDATA,
   // Operational window decode.
   input wire logic [23:0] OPS_ADDR,
   output logic OPS_HIT,
   output logic [23:0] OPS_BASE,
   output logic [7:0] LOGICAL_ADDR,
   output logic A24_ENABLE,
   output logic SOFT_RESET
);

   // ==========================================================================
   // State and decode signals.

   vcd_state_t r;
   vcd_state_t next_r;
   logic [7:0] cur_la;
   logic hit;
   logic [5:0] ofs;

   // ==========================================================================
   // Helpers.

   // Window size in bytes follows 2^(23-m).
   function automatic logic [23:0] win_mask(input logic [3:0] m);
      win_mask = 24'hFFFFFF >> (5'(m) + 5'h1);
   endfunction : win_mask

   // ==========================================================================
   // Address decode.

   // Logical address in force: switch, unless it reads all ones.
   always_comb begin
      cur_la = (LA_SWITCH == `VCD_LA_DYNAMIC) ? r.la : LA_SWITCH;
      ofs = ACC_ADDR[5:0];
      hit = ACC_STB && ACC_D16 && (ACC_ADDR[15:14] == `VCD_TOP_BITS)
         && (ACC_ADDR[13:6] == cur_la) && !ofs[0]
         && ((cur_la != `VCD_LA_DYNAMIC) || r.sel || r.la_written);
   end

   // ==========================================================================
   // Next state.

   always_comb begin
      next_r = r;
      next_r.sel_sync = {r.sel_sync[1:0], MODULE_SELECT_LINE};
      if (r.sel_sync[2] == r.sel_sync[1]) begin
         next_r.sel = r.sel_sync[1];
      end
      next_r.ack = hit;
      next_r.rdata = r.rdata;
      if (hit && !ACC_WR) begin
         case (ofs)
            `VCD_OFS_IDENT: next_r.rdata = {`VCD_CLASS_EXT, ADDR_MODE, MAKER_ID};
            `VCD_OFS_DEVTYPE: next_r.rdata = {REQ_MEM, MODEL_CODE};
            `VCD_OFS_STATUS: next_r.rdata = {r.a24_enable, !r.sel, 13'h0000, r.soft_reset}
               | `VCD_STATUS_FILL;
            `VCD_OFS_WBASE: next_r.rdata = r.wbase;
            default: next_r.rdata = `VCD_UNIMPL_DATA;
         endcase
      end
      if (hit && ACC_WR) begin
         case (ofs)
            `VCD_OFS_IDENT: begin
               if (LA_SWITCH == `VCD_LA_DYNAMIC) begin
                  next_r.la = ACC_WDATA[7:0];
                  next_r.la_written = 1'b1;
               end
            end
            `VCD_OFS_STATUS: begin
               next_r.a24_enable = ACC_WDATA[15];
               next_r.soft_reset = ACC_WDATA[0];
            end
            `VCD_OFS_WBASE: next_r.wbase = ACC_WDATA;
            default: next_r.wbase = r.wbase;
         endcase
      end
   end

   // ==========================================================================
   // State register.

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         r <= '0;
         r.la <= `VCD_LA_DYNAMIC;
         r.wbase <= `VCD_WBASE_RESET;
         r.rdata <= `VCD_UNIMPL_DATA;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================================
   // Outputs.

   always_comb begin
      ACC_ACK = r.ack;
      ACC_RDATA = r.rdata;
      LOGICAL_ADDR = cur_la;
      A24_ENABLE = r.a24_enable;
      SOFT_RESET = r.soft_reset;
      OPS_BASE = {r.wbase[15:6], 14'h0000} & ~win_mask(REQ_MEM);
      OPS_HIT = r.a24_enable && ((OPS_ADDR & ~win_mask(REQ_MEM)) == OPS_BASE);
   end

   // ==========================================================================
   // Access sequences.

   sequence seq_read_at(logic [5:0] o);
      hit && !ACC_WR && ofs == o;
   endsequence

   sequence seq_write_at(logic [5:0] o);
      hit && ACC_WR && ofs == o;
   endsequence

   sequence seq_foreign;
      ACC_STB && !hit;
   endsequence

   sequence seq_sel_settled;
      r.sel_sync[2] == r.sel_sync[1];
   endsequence

   // ==========================================================================
   // Assertions.

   AST_NO_ACK_WRONG_TOP: assert property (@(posedge CLK) disable iff (!RST_N)
      ACC_STB && ACC_ADDR[15:14] != `VCD_TOP_BITS |=> !ACC_ACK) else $error("ack outside top region");

   AST_NO_ACK_WRONG_LA: assert property (@(posedge CLK) disable iff (!RST_N)
      ACC_STB && ACC_ADDR[13:6] != cur_la |=> !ACC_ACK) else $error("ack on foreign address");

   AST_D16_ONLY: assert property (@(posedge CLK) disable iff (!RST_N)
      ACC_STB && !ACC_D16 |=> !ACC_ACK) else $error("ack on non D16 transfer");

   AST_ID_READ: assert property (@(posedge CLK) disable iff (!RST_N)
      hit && !ACC_WR && ofs == `VCD_OFS_IDENT |=> ACC_ACK && ACC_RDATA[15:14] == `VCD_CLASS_EXT
      && ACC_RDATA[11:0] == MAKER_ID) else $error("bad identification read");

   AST_DEVTYPE_READ: assert property (@(posedge CLK) disable iff (!RST_N)
      hit && !ACC_WR && ofs == `VCD_OFS_DEVTYPE |=> ACC_RDATA[15:12] == REQ_MEM)
      else $error("bad required memory");

   AST_UNIMPL_READ: assert property (@(posedge CLK) disable iff (!RST_N)
      hit && !ACC_WR && ofs > `VCD_OFS_WBASE |=> ACC_RDATA == `VCD_UNIMPL_DATA)
      else $error("bad unimplemented read");

   AST_WBASE_WRITE: assert property (@(posedge CLK) disable iff (!RST_N)
      hit && ACC_WR && ofs == `VCD_OFS_WBASE |=> r.wbase == $past(ACC_WDATA))
      else $error("window base not written");

   AST_SEL_GATE: assert property (@(posedge CLK) disable iff (!RST_N)
      ACC_STB && cur_la == `VCD_LA_DYNAMIC && !r.sel && !r.la_written |=> !ACC_ACK)
      else $error("ack without select");

   AST_BASE_LOW: assert property (@(posedge CLK) disable iff (!RST_N)
      OPS_BASE[13:0] == 14'h0000) else $error("window base low bits set");

   AST_ACK_AFTER_HIT: assert property (@(posedge CLK) disable iff (!RST_N)
      hit
      |=> ACC_ACK)
      else $error("accepted access not acknowledged");

   AST_ACK_ONLY_AFTER_HIT: assert property (@(posedge CLK) disable iff (!RST_N)
      !hit
      |=> !ACC_ACK)
      else $error("acknowledge without accepted access");

   AST_FOREIGN_NO_ACK: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_foreign
      |=> !ACC_ACK)
      else $error("refused access acknowledged");

   AST_ODD_REFUSED: assert property (@(posedge CLK) disable iff (!RST_N)
      ACC_STB && ACC_ADDR[0]
      |=> !ACC_ACK)
      else $error("odd address acknowledged");

   AST_DEVTYPE_WORD: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_read_at(`VCD_OFS_DEVTYPE)
      |=> ACC_RDATA == {REQ_MEM, MODEL_CODE})
      else $error("bad device type word");

   AST_ID_MODE: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_read_at(`VCD_OFS_IDENT)
      |=> ACC_RDATA[13:12] == ADDR_MODE)
      else $error("bad addressing mode field");

   AST_ID_WORD: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_read_at(`VCD_OFS_IDENT)
      |=> ACC_RDATA == {`VCD_CLASS_EXT, ADDR_MODE, MAKER_ID})
      else $error("bad identification word");

   AST_WBASE_READ: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_read_at(`VCD_OFS_WBASE)
      |=> ACC_RDATA == $past(r.wbase))
      else $error("window base read mismatch");

   AST_LAST_OFS: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_read_at(`VCD_OFS_LAST)
      |=> ACC_ACK && ACC_RDATA == `VCD_UNIMPL_DATA)
      else $error("last offset not answered");

   AST_RDATA_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
      !(hit && !ACC_WR)
      |=> $stable(ACC_RDATA))
      else $error("read data moved without a read");

   AST_ID_READ_ONLY: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_write_at(`VCD_OFS_IDENT)
      |=> $stable(ACC_RDATA))
      else $error("write disturbed read data");

   AST_STATIC_LA: assert property (@(posedge CLK) disable iff (!RST_N)
      LA_SWITCH != `VCD_LA_DYNAMIC
      |-> LOGICAL_ADDR == LA_SWITCH)
      else $error("static address not in force");

   AST_DYN_LA: assert property (@(posedge CLK) disable iff (!RST_N)
      LA_SWITCH == `VCD_LA_DYNAMIC
      |-> LOGICAL_ADDR == r.la)
      else $error("dynamic address not in force");

   AST_LA_LOAD: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_write_at(`VCD_OFS_IDENT) ##0 (LA_SWITCH == `VCD_LA_DYNAMIC)
      |=> r.la == $past(ACC_WDATA[7:0]))
      else $error("logical address not loaded");

   AST_LA_WRITTEN: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_write_at(`VCD_OFS_IDENT) ##0 (LA_SWITCH == `VCD_LA_DYNAMIC)
      |=> r.la_written)
      else $error("written mark not set");

   AST_STATIC_LA_KEEP: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_write_at(`VCD_OFS_IDENT) ##0 (LA_SWITCH != `VCD_LA_DYNAMIC)
      |=> $stable(r.la))
      else $error("address register loaded in static mode");

   AST_WRITTEN_STICKY: assert property (@(posedge CLK) disable iff (!RST_N)
      r.la_written
      |=> r.la_written)
      else $error("written mark lost");

   AST_SEL_UNSETTLED: assert property (@(posedge CLK) disable iff (!RST_N)
      r.sel_sync[2] != r.sel_sync[1]
      |=> $stable(r.sel))
      else $error("select taken before stages agree");

   AST_SEL_SETTLED: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_sel_settled
      |=> r.sel == $past(r.sel_sync[1]))
      else $error("settled select not taken");

   AST_STATUS_SEL: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_read_at(`VCD_OFS_STATUS)
      |=> ACC_RDATA[14] == !$past(r.sel))
      else $error("select flag misreported");

   AST_CTRL_A24: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_write_at(`VCD_OFS_STATUS)
      |=> A24_ENABLE == $past(ACC_WDATA[15]))
      else $error("window enable not written");

   AST_CTRL_SOFT: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_write_at(`VCD_OFS_STATUS)
      |=> SOFT_RESET == $past(ACC_WDATA[0]))
      else $error("soft reset not written");

   AST_WBASE_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
      !(hit && ACC_WR && ofs == `VCD_OFS_WBASE)
      |=> $stable(r.wbase))
      else $error("window base moved without a write");

   AST_OPS_OFF: assert property (@(posedge CLK) disable iff (!RST_N)
      !A24_ENABLE
      |-> !OPS_HIT)
      else $error("window hit while disabled");

   AST_BASE_MASK: assert property (@(posedge CLK) disable iff (!RST_N)
      (OPS_BASE & win_mask(REQ_MEM))
      == 24'h000000)
      else $error("window base below window size");

endmodule : vcd_config_space
`default_nettype wire

/* File: core/vcd_defs.svh */
// Constants of the configuration-space decoder.
// Notes on behaviour
// - A 64-byte configuration block in A16 space; only it is answered.
// - Address bits 13..6 match logical address, bits 15..14 high, bits 5..0 offset.
// - Block base is logical address times 40h plus C000h.
// - Word offsets run from 00h to 3Eh inclusive.
// - Switch value 255 selects dynamic addressing; otherwise switch is the address.
// - In dynamic mode the address sits in a write-only register loaded by host.
// - While address is 255, answer only with module select line asserted.
// - After a new address is written, decode it whatever module select does.
// - Provide identification, device type, status/control and window base registers.
// - Configuration registers take 16-bit transfers only.
// - Device type bits 15..12 report the required-memory code.
// - Code 0 means 8 Mbytes, each step halves, 15 means 256 bytes.
// - Window base is a 16-bit read/write register setting the A24 window.
// - Top m+1 window base bits give top m+1 operational address bits; code takes only bits 15..6, so for m above 9 bits 5..0 are ignored.
// - Identification is read-only: class bits 15..14 = 01, mode, maker code.
// - Addressing mode bits 13..12 read 00 for A24, 01 for A32.
// - Identification bits 11..0 return the fixed maker code.
// - Window base address is bits 15..6 shifted left by 8.
`ifndef VCD_DEFS_SVH
`define VCD_DEFS_SVH
`define VCD_OFS_IDENT 6'h00
`define VCD_OFS_DEVTYPE 6'h02
`define VCD_OFS_STATUS 6'h04
`define VCD_OFS_WBASE 6'h06
`define VCD_OFS_LAST 6'h3E
`define VCD_TOP_BITS 2'h3
`define VCD_LA_DYNAMIC 8'hFF
`define VCD_CLASS_EXT 2'h1
`define VCD_MODE_A24 2'h0
`define VCD_MODE_A32 2'h1
`define VCD_UNIMPL_DATA 16'hFFFF
`define VCD_STATUS_FILL 16'h3FF6
`define VCD_WBASE_RESET 16'h0000
`define VCD_A24_TOP_BIT 23
`define VCD_WBASE_SHIFT 8
`endif

/* File: core/vcd_pkg.sv */
// Types of the configuration-space decoder.
package vcd_pkg;
   typedef struct packed {
      logic [2:0] sel_sync;
      logic sel;
      logic [7:0] la;
      logic la_written;
      logic [15:0] wbase;
      logic a24_enable;
      logic soft_reset;
      logic ack;
      logic [15:0] rdata;
   } vcd_state_t;
endpackage : vcd_pkg

/* File: test/vcd_host.sv */
// Host model that issues single-word configuration accesses.
`timescale 1ns/1ps
`default_nettype none
module vcd_host (
   // Clock.
   input wire logic CLK,
   // Access request.
   output logic ACC_STB,
   output logic ACC_WR,
   output logic ACC_D16,
   output logic [15:0] ACC_ADDR,
   output logic [15:0] ACC_WDATA,
   // Answer.
   input wire logic ACC_ACK,
   input wire logic [15:0] ACC_RDATA
);
   initial begin
      ACC_STB = 1'h0;
      ACC_WR = 1'h0;
      ACC_D16 = 1'h1;
      ACC_ADDR = 16'h0000;
      ACC_WDATA = 16'h0000;
   end
   task automatic acc(input logic w, d, input logic [15:0] a, wd, output logic k, output logic [15:0] r);
      @(posedge CLK);
      ACC_STB <= 1'h1;
      ACC_WR <= w;
      ACC_D16 <= d;
      ACC_ADDR <= a;
      ACC_WDATA <= wd;
      @(posedge CLK);
      ACC_STB <= 1'h0;
      ACC_ADDR <= ~a;
      ACC_WDATA <= ~wd;
      #1;
      k = ACC_ACK;
      r = ACC_RDATA;
   endtask : acc
endmodule : vcd_host
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench of the configuration-space decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic CLK = 1'h0, RST_N = 1'h0, sel = 1'h0, ack, ak, hit, stb, wr, d16, a24, srst;
   logic [7:0] sw = 8'h05, la;
   logic [15:0] rd, rdw, addr, wd;
   logic [23:0] ops = 24'h000000, base;
   int mismatches = 0, total_checks = 0, cyc = 0;
   always #20 CLK = ~CLK;
   vcd_host host (.CLK(CLK), .ACC_STB(stb), .ACC_WR(wr), .ACC_D16(d16), .ACC_ADDR(addr), .ACC_WDATA(wd),
      .ACC_ACK(ak), .ACC_RDATA(rdw));
   vcd_config_space dut (.CLK(CLK), .RST_N(RST_N), .LA_SWITCH(sw), .MODULE_SELECT_LINE(sel), .ACC_STB(stb),
      .ACC_WR(wr), .ACC_D16(d16), .ACC_ADDR(addr), .ACC_WDATA(wd), .ACC_ACK(ak), .ACC_RDATA(rdw),
      .OPS_ADDR(ops), .OPS_HIT(hit), .OPS_BASE(base), .LOGICAL_ADDR(la), .A24_ENABLE(a24), .SOFT_RESET(srst));
   function automatic logic [15:0] blk(input logic [7:0] v);
      return 16'hC000 + {2'h0, v, 6'h00};
   endfunction : blk
   task automatic check(input logic [23:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic do_reset(input logic [7:0] s);
      @(posedge CLK);
      RST_N <= 1'h0;
      sw <= s;
      repeat (16) @(posedge CLK);
      RST_N <= 1'h1;
   endtask : do_reset
   task automatic test_static;
      logic [15:0] bad [3] = '{16'hC180, 16'hC141, 16'h4140};
      do_reset(8'h05);
      host.acc(1'h1, 1'h1, blk(8'h05), 16'h0000, ack, rd);
      host.acc(1'h0, 1'h1, blk(8'h05), 16'h0000, ack, rd);
      check({ack, rd}, 17'h14123);
      host.acc(1'h0, 1'h1, blk(8'h05) | 16'h0002, 16'h0000, ack, rd);
      check(rd, 16'h9001);
      host.acc(1'h0, 1'h1, blk(8'h05) | 16'h003E, 16'h0000, ack, rd);
      check({ack, rd}, 17'h1FFFF);
      host.acc(1'h1, 1'h1, blk(8'h05) | 16'h0006, 16'hABCD, ack, rd);
      host.acc(1'h0, 1'h1, blk(8'h05) | 16'h0006, 16'h0000, ack, rd);
      check(rd, 16'hABCD);
      check(base, 24'hABC000);
      host.acc(1'h1, 1'h1, blk(8'h05) | 16'h0004, 16'h8000, ack, rd);
      check({a24, srst}, 2'h2);
      @(posedge CLK) ops <= 24'hABFFFE;
      #1 check(hit, 1'h1);
      @(posedge CLK) ops <= 24'hAC0000;
      #1 check(hit, 1'h0);
      foreach (bad[i]) begin
         host.acc(1'h0, 1'h1, bad[i], 16'h0000, ack, rd);
         check(ack, 1'h0);
      end
      host.acc(1'h0, 1'h0, blk(8'h05), 16'h0000, ack, rd);
      check(ack, 1'h0);
      $display("static address test done");
   endtask : test_static
   task automatic test_dynamic;
      do_reset(8'hFF);
      host.acc(1'h0, 1'h1, blk(8'hFF), 16'h0000, ack, rd);
      check(ack, 1'h0);
      @(posedge CLK) sel <= 1'h1;
      repeat (6) @(posedge CLK);
      host.acc(1'h0, 1'h1, blk(8'hFF) | 16'h0004, 16'h0000, ack, rd);
      check({ack, rd[14]}, 2'h2);
      host.acc(1'h1, 1'h1, blk(8'hFF), 16'h0012, ack, rd);
      check(la, 8'h12);
      @(posedge CLK) sel <= 1'h0;
      repeat (6) @(posedge CLK);
      host.acc(1'h0, 1'h1, blk(8'h12) | 16'h0002, 16'h0000, ack, rd);
      check({ack, rd}, 17'h19001);
      $display("dynamic address test done");
   endtask : test_dynamic
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         mismatches++;
         wrap_up;
      end
   end
   initial begin
      test_static;
      test_dynamic;
      wrap_up;
   end
endmodule : tb
`default_nettype wire
